// ===== logic/rtc_event_defines.svh
// Purpose: Constants for the alarm, cyclic interrupt and interval timer block
// Assumes: 8-bit register port, 4-bit register index
// Notes:   Period codes are shared by the cyclic interrupt and the timer
`ifndef RTC_EVENT_DEFINES_SVH
`define RTC_EVENT_DEFINES_SVH

// ==================================================================
// Register indices
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_ALARM_MIN     4'h2
`define REG_ALARM_HOUR    4'h3
`define REG_CYC_SEL       4'h4
`define REG_TIMER_SEL     4'h5

// ==================================================================
// Field positions
`define CTRL_ALARM_EN     0
`define CTRL_RESTART      1
`define CTRL_GATE         2
`define STAT_ALARM        0
`define STAT_CYCLIC       1
`define STAT_OSC_STOP     2
`define STAT_CE           3
`define CYC_LEVEL_BIT     3

// ==================================================================
// Reset values
`define RST_BYTE          8'h00
`define RST_SEL           4'h0
`define RST_TSEL          3'h0
`define RST_PRESC         16'h0000
`define PRESC_STEP        16'h0001

// ==================================================================
// Timing: base tick of 1/4096 s, periods counted in base ticks
`define BASE_TICK_NS      244141
`define CLK_PERIOD_NS     4
`define PER_0488US        18'h0_0002
`define PER_0977US        18'h0_0004
`define PER_7813US        18'h0_0020
`define PER_62500US       18'h0_0100
`define PER_1S            18'h0_1000
`define PER_60S           18'h3_C000
`define PER_NONE          18'h0_0000
`define PER_ONE           18'h0_0001
`define PULSE_TICKS       18'h0_0001

`endif

// ===== logic/rtc_event_pkg.sv
// Purpose: Types shared by the event block and its bench
// Assumes: Constants come from rtc_event_defines.svh
// Notes:   Open-drain pins travel as level plus active-low enable
package rtc_event_pkg;

	// ==================================================================
	// Register port request
	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;

	// ==================================================================
	// Open-drain pin: enable low means the pin is pulled low
	typedef struct packed
	{
		logic level;
		logic oe_n;
	} od_pin_s;

	typedef logic [17:0] tick_cnt_t;

endpackage : rtc_event_pkg

// ===== logic/rtc_alarm_cyclic_timer_irq.sv
// Purpose: Alarm, cyclic interrupt, interval timer and oscillator-stop flag
// Assumes: Time counter supplies BCD minutes and hours on the same clock
// Notes:   Chip enable and oscillator stop arrive from pins, synchronised here
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "rtc_event_defines.svh"

module rtc_alarm_cyclic_timer_irq #(
	parameter int TICK_CYCLES = `BASE_TICK_NS / `CLK_PERIOD_NS
)(
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire rtc_event_pkg::bus_req_s  bus_in,
	output logic [7:0]                    rdata_out,
	input  wire logic [7:0]               cur_minute_in,
	input  wire logic [7:0]               cur_hour_in,
	input  wire logic                     chip_enable_in,
	input  wire logic                     osc_stop_in,
	output rtc_event_pkg::od_pin_s        interrupt_request_n_out,
	output rtc_event_pkg::od_pin_s        timer_pulse_out_n_out
);

	// ==================================================================
	// Period decode shared by cyclic interrupt and timer
	function automatic rtc_event_pkg::tick_cnt_t period_ticks(input logic [2:0] code);
		period_ticks = `PER_NONE;
		case (code)
			3'h1: period_ticks = `PER_0488US;
			3'h2: period_ticks = `PER_0977US;
			3'h3: period_ticks = `PER_7813US;
			3'h4: period_ticks = `PER_62500US;
			3'h5: period_ticks = `PER_1S;
			3'h6: period_ticks = `PER_60S;
			default: period_ticks = `PER_NONE;
		endcase
	endfunction : period_ticks

	// ==================================================================
	// Declarations
	logic [15:0]               presc_r;
	logic                      base_tick;
	logic [2:0]                ce_sync_r;
	logic                      ce_ok_r;
	logic [2:0]                osc_sync_r;
	logic                      osc_stopped_r;
	logic                      osc_evt;
	logic                      alarm_enable_r;
	logic                      timer_output_gate_r;
	logic [7:0]                alarm_min_r;
	logic [7:0]                alarm_hour_r;
	logic [3:0]                cyc_sel_r;
	logic [2:0]                timer_sel_r;
	logic                      osc_stop_flag_r;
	logic                      alarm_match;
	logic                      alarm_match_r;
	logic                      alarm_pend_r;
	rtc_event_pkg::tick_cnt_t  cyc_period;
	rtc_event_pkg::tick_cnt_t  cyc_cnt_r;
	logic                      cyc_evt;
	logic                      cyc_level_select;
	logic                      cyc_level_r;
	rtc_event_pkg::tick_cnt_t  cyc_pulse_r;
	logic                      cyc_req;
	rtc_event_pkg::tick_cnt_t  timer_period;
	rtc_event_pkg::tick_cnt_t  timer_cnt_r;
	logic                      timer_evt;
	logic                      timer_pulse_r;
	logic                      restart_wr;
	logic                      wr_ctrl;
	logic                      wr_status;
	logic [7:0]                rdata_nxt;

	// ==================================================================
	// Write decode
	assign wr_ctrl    = bus_in.wr && (bus_in.addr == `REG_CTRL);
	assign wr_status  = bus_in.wr && (bus_in.addr == `REG_STATUS);
	assign restart_wr = wr_ctrl && bus_in.wdata[`CTRL_RESTART];

	// ==================================================================
	// Base tick prescaler, 1/4096 s
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			presc_r <= `RST_PRESC;
		else if (base_tick)
			presc_r <= `RST_PRESC;
		else
			presc_r <= presc_r + `PRESC_STEP;
	end

	assign base_tick = (presc_r == 16'(TICK_CYCLES - 1));

	// ==================================================================
	// Pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ce_sync_r     <= 3'h0;
			ce_ok_r       <= 1'b0;
			osc_sync_r    <= 3'h0;
			osc_stopped_r <= 1'b0;
		end
		else
		begin
			ce_sync_r  <= {ce_sync_r[1:0], chip_enable_in};
			osc_sync_r <= {osc_sync_r[1:0], osc_stop_in};
			if (ce_sync_r[1] == ce_sync_r[2])
				ce_ok_r <= ce_sync_r[2];
			if (osc_sync_r[1] == osc_sync_r[2])
				osc_stopped_r <= osc_sync_r[2];
		end
	end

	assign osc_evt = (osc_sync_r[1] == osc_sync_r[2]) && osc_sync_r[2] && !osc_stopped_r;

	// ==================================================================
	// Configuration registers
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			alarm_enable_r <= 1'b0;
			alarm_min_r    <= `RST_BYTE;
			alarm_hour_r   <= `RST_BYTE;
			cyc_sel_r      <= `RST_SEL;
			timer_sel_r    <= `RST_TSEL;
		end
		else if (bus_in.wr)
		begin
			case (bus_in.addr)
				`REG_CTRL:       alarm_enable_r <= bus_in.wdata[`CTRL_ALARM_EN];
				`REG_ALARM_MIN:  alarm_min_r    <= bus_in.wdata;
				`REG_ALARM_HOUR: alarm_hour_r   <= bus_in.wdata;
				`REG_CYC_SEL:    cyc_sel_r      <= bus_in.wdata[3:0];
				`REG_TIMER_SEL:  timer_sel_r    <= bus_in.wdata[2:0];
				default:         alarm_enable_r <= alarm_enable_r;
			endcase
		end
	end

	// ==================================================================
	// Timer output gate: oscillator stop wins over a write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			timer_output_gate_r <= 1'b0;
		else if (osc_evt)
			timer_output_gate_r <= 1'b0;
		else if (wr_ctrl)
			timer_output_gate_r <= bus_in.wdata[`CTRL_GATE];
	end

	// ==================================================================
	// Oscillator stop flag: set at power-up and on detection
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			osc_stop_flag_r <= 1'b1;
		else if (osc_evt)
			osc_stop_flag_r <= 1'b1;
		else if (wr_status && !bus_in.wdata[`STAT_OSC_STOP])
			osc_stop_flag_r <= 1'b0;
	end

	// ==================================================================
	// Alarm: match start sets the request, flag write of zero or disable clears
	assign alarm_match = alarm_enable_r && (alarm_min_r == cur_minute_in)
		&& (alarm_hour_r == cur_hour_in);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			alarm_match_r <= 1'b0;
			alarm_pend_r  <= 1'b0;
		end
		else
		begin
			alarm_match_r <= alarm_match;
			if (alarm_match && !alarm_match_r)
				alarm_pend_r <= 1'b1;
			else if (!alarm_enable_r || (wr_status && !bus_in.wdata[`STAT_ALARM]))
				alarm_pend_r <= 1'b0;
		end
	end

	// ==================================================================
	// Cyclic counter, free of chip enable
	assign cyc_period       = period_ticks(cyc_sel_r[2:0]);
	assign cyc_level_select = cyc_sel_r[`CYC_LEVEL_BIT];
	assign cyc_evt          = base_tick && (cyc_period != `PER_NONE)
		&& (cyc_cnt_r >= cyc_period - `PER_ONE);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cyc_cnt_r <= `PER_NONE;
		else if (cyc_period == `PER_NONE)
			cyc_cnt_r <= `PER_NONE;
		else if (cyc_evt)
			cyc_cnt_r <= `PER_NONE;
		else if (base_tick)
			cyc_cnt_r <= cyc_cnt_r + `PER_ONE;
	end

	// Level mode request: a new period wins over a clearing write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cyc_level_r <= 1'b0;
		else if (cyc_period == `PER_NONE)
			cyc_level_r <= 1'b0;
		else if (cyc_evt && cyc_level_select)
			cyc_level_r <= 1'b1;
		else if (wr_status && !bus_in.wdata[`STAT_CYCLIC])
			cyc_level_r <= 1'b0;
	end

	// Pulse mode request lasts a fixed number of base ticks
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cyc_pulse_r <= `PER_NONE;
		else if (cyc_period == `PER_NONE)
			cyc_pulse_r <= `PER_NONE;
		else if (cyc_evt && !cyc_level_select)
			cyc_pulse_r <= `PULSE_TICKS;
		else if (base_tick && (cyc_pulse_r != `PER_NONE))
			cyc_pulse_r <= cyc_pulse_r - `PER_ONE;
	end

	assign cyc_req = cyc_level_r || (cyc_pulse_r != `PER_NONE);

	// ==================================================================
	// Interval timer, halted while chip enable is low
	assign timer_period = period_ticks(timer_sel_r);
	assign timer_evt    = ce_ok_r && base_tick && (timer_period != `PER_NONE)
		&& (timer_cnt_r >= timer_period - `PER_ONE);

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			timer_cnt_r <= `PER_NONE;
		else if (restart_wr || (timer_period == `PER_NONE))
			timer_cnt_r <= `PER_NONE;
		else if (timer_evt)
			timer_cnt_r <= `PER_NONE;
		else if (ce_ok_r && base_tick)
			timer_cnt_r <= timer_cnt_r + `PER_ONE;
	end

	// Timer pulse of one base tick, cut short by a restart
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			timer_pulse_r <= 1'b0;
		else if (restart_wr)
			timer_pulse_r <= 1'b0;
		else if (timer_evt)
			timer_pulse_r <= 1'b1;
		else if (ce_ok_r && base_tick)
			timer_pulse_r <= 1'b0;
	end

	// ==================================================================
	// Open-drain pins: level always low, enable low while pulling
	assign interrupt_request_n_out.level = 1'b0;
	assign interrupt_request_n_out.oe_n  = !(alarm_pend_r || cyc_req);
	assign timer_pulse_out_n_out.level   = 1'b0;
	assign timer_pulse_out_n_out.oe_n    = !(timer_pulse_r && timer_output_gate_r);

	// ==================================================================
	// Read mux; flags are the inverse of the pin contribution
	always_comb
	begin
		rdata_nxt = `RST_BYTE;
		case (bus_in.addr)
			`REG_CTRL:
			begin
				rdata_nxt[`CTRL_ALARM_EN] = alarm_enable_r;
				rdata_nxt[`CTRL_GATE]     = timer_output_gate_r;
			end
			`REG_STATUS:
			begin
				rdata_nxt[`STAT_ALARM]    = alarm_pend_r;
				rdata_nxt[`STAT_CYCLIC]   = cyc_req;
				rdata_nxt[`STAT_OSC_STOP] = osc_stop_flag_r;
				rdata_nxt[`STAT_CE]       = ce_ok_r;
			end
			`REG_ALARM_MIN:  rdata_nxt = alarm_min_r;
			`REG_ALARM_HOUR: rdata_nxt = alarm_hour_r;
			`REG_CYC_SEL:    rdata_nxt = {4'h0, cyc_sel_r};
			`REG_TIMER_SEL:  rdata_nxt = {5'h00, timer_sel_r};
			default:         rdata_nxt = `RST_BYTE;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_out <= `RST_BYTE;
		else if (bus_in.rd)
			rdata_out <= rdata_nxt;
		else
			rdata_out <= `RST_BYTE;
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_alarm_match_sets: assert property (
		(alarm_match && !alarm_match_r) |=> !interrupt_request_n_out.oe_n)
		else $error("alarm match did not pull interrupt low");
	a_irq_or_sources: assert property (
		interrupt_request_n_out.oe_n == !(alarm_pend_r || cyc_req))
		else $error("interrupt is not the OR of sources");
	a_alarm_flag_read: assert property (
		(bus_in.rd && bus_in.addr == `REG_STATUS && !cyc_req)
		|=> rdata_out[`STAT_ALARM] == !$past(interrupt_request_n_out.oe_n))
		else $error("alarm flag does not mirror the pin");
	a_cyc_cancel: assert property (
		(cyc_period == `PER_NONE) |=> !cyc_level_r && (cyc_pulse_r == `PER_NONE))
		else $error("cancelled cyclic request still active");
	a_cyc_level_clear: assert property (
		(wr_status && !bus_in.wdata[`STAT_CYCLIC] && !cyc_evt) |=> !cyc_level_r)
		else $error("cyclic level request not cleared");
	a_cyc_level_hold: assert property (
		(cyc_evt && cyc_level_select && !ce_ok_r) |=> cyc_level_r)
		else $error("cyclic level request lost with chip enable low");
	a_timer_restart: assert property (
		restart_wr |=> (timer_cnt_r == `PER_NONE) && timer_pulse_out_n_out.oe_n)
		else $error("restart did not clear timer");
	a_timer_halt: assert property (
		(!ce_ok_r && !restart_wr && timer_period == $past(timer_period)) |=> $stable(timer_cnt_r))
		else $error("timer counted with chip enable low");
	a_osc_stop: assert property (
		osc_evt |=> !timer_output_gate_r && osc_stop_flag_r)
		else $error("oscillator stop not handled");

endmodule : rtc_alarm_cyclic_timer_irq

// ===== testbench/rtc_host_model.sv
// Purpose: Host side of the event block: pull-ups on both open-drain pins
// Assumes: Pins arrive as level plus active-low enable
// Notes:   A released pin reads high through its pull-up, never a stale value
`timescale 1ns/100ps

module rtc_host_model (
	input  wire logic                   clk_in,
	input  wire rtc_event_pkg::od_pin_s irq_pin_in,
	input  wire rtc_event_pkg::od_pin_s tmr_pin_in,
	output logic                        irq_line_n_out,
	output logic                        tmr_line_n_out,
	output int                          irq_falls_out,
	output int                          tmr_falls_out
);
	logic irq_d;
	logic tmr_d;

	// ==================================================================
	// Wire levels: low only while the pin enable is low
	assign irq_line_n_out = (irq_pin_in.oe_n === 1'b0) ? irq_pin_in.level : 1'b1;
	assign tmr_line_n_out = (tmr_pin_in.oe_n === 1'b0) ? tmr_pin_in.level : 1'b1;

	// Count the requests the host services
	initial
	begin
		irq_falls_out = 0;
		tmr_falls_out = 0;
		irq_d = 1'b1;
		tmr_d = 1'b1;
	end

	always @(posedge clk_in)
	begin
		if (irq_d && !irq_line_n_out) irq_falls_out++;
		if (tmr_d && !tmr_line_n_out) tmr_falls_out++;
		irq_d <= irq_line_n_out;
		tmr_d <= tmr_line_n_out;
	end
endmodule : rtc_host_model

// ===== testbench/rtc_alarm_cyclic_timer_irq_bench.sv
// Purpose: Self-checking bench for the alarm, cyclic and timer block
// Assumes: Base tick shortened to 4 clocks
// Notes:   The 60 s period is skipped to keep the run short
`timescale 1ns/100ps
`include "rtc_event_defines.svh"

module rtc_alarm_cyclic_timer_irq_bench;
	localparam int TICK = 4;
	logic                    clk_in;
	logic                    rst_n_in;
	rtc_event_pkg::bus_req_s bus;
	logic [7:0]              rdata_out;
	logic [7:0]              cur_min;
	logic [7:0]              cur_hour;
	logic                    ce;
	logic                    osc_stop;
	rtc_event_pkg::od_pin_s  irq_pin;
	rtc_event_pkg::od_pin_s  tmr_pin;
	logic                    irq_n;
	logic                    tmr_n;
	int                      irq_falls;
	int                      tmr_falls;
	int                      fails;
	int                      n_checks;
	int                      per;
	int                      wid;
	int                      n;
	int                      c0;
	int                      ticks [1:5] = '{2, 4, 32, 256, 4096};

	rtc_alarm_cyclic_timer_irq #(.TICK_CYCLES(TICK)) DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata_out),
		.cur_minute_in(cur_min), .cur_hour_in(cur_hour), .chip_enable_in(ce),
		.osc_stop_in(osc_stop), .interrupt_request_n_out(irq_pin),
		.timer_pulse_out_n_out(tmr_pin)
	);

	rtc_host_model host (
		.clk_in(clk_in), .irq_pin_in(irq_pin), .tmr_pin_in(tmr_pin),
		.irq_line_n_out(irq_n), .tmr_line_n_out(tmr_n),
		.irq_falls_out(irq_falls), .tmr_falls_out(tmr_falls)
	);

	// ==================================================================
	// Clock and inputs at time zero
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// ==================================================================
	// Register port tasks and comparisons
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clk_in);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %0t: read %h expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_cond(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("Error %0t: %s", $time, what);
		end
	endtask : chk_cond

	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk_in);
		bus.rd <= 1'b0;
		@(negedge clk_in);
		chk_byte(rdata_out, exp);
	endtask : rchk

	// Wait at falling edges until the chosen line shows lvl, bounded
	task automatic until_lvl(input bit t, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		@(negedge clk_in);
		while ((t ? tmr_n : irq_n) !== lvl && cnt < lim)
		begin
			@(negedge clk_in);
			cnt++;
		end
	endtask : until_lvl

	// Period fall to fall and low width of one line
	task automatic measure(input bit t, output int p, output int w);
		int r;
		until_lvl(t, 1'b1, 40000, r);
		until_lvl(t, 1'b0, 40000, r);
		until_lvl(t, 1'b1, 40000, w);
		until_lvl(t, 1'b0, 40000, r);
		w++;
		p = w + r + 1;
	endtask : measure

	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// Watchdog: the run needs about 40000 cycles, this allows 60000
	initial
	begin
		#240000;
		fails++;
		conclude();
	end

	// ==================================================================
	// Main sequence
	initial
	begin
		fails = 0;
		n_checks = 0;
		bus = '0;
		cur_min = 8'h29;
		cur_hour = 8'h12;
		ce = 1'b1;
		osc_stop = 1'b0;
		rst_n_in = 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rchk(`REG_STATUS, 8'h0C);
		rchk(`REG_CTRL, 8'h00);
		wr(`REG_STATUS, 8'h00);
		wr(4'hF, 8'hFF);
		rchk(4'hF, 8'h00);
		rchk(`REG_STATUS, 8'h08);
		// Alarm armed after its time is written, then the time reaches it
		wr(`REG_ALARM_MIN, 8'h30);
		wr(`REG_ALARM_HOUR, 8'h12);
		wr(`REG_CTRL, 8'h01);
		@(negedge clk_in);
		chk_cond(irq_n === 1'b1, "alarm before match");
		@(posedge clk_in);
		cur_min <= 8'h30;
		until_lvl(0, 1'b0, 3, n);
		chk_cond(n <= 2, "alarm not asserted");
		rchk(`REG_STATUS, 8'h09);
		// Alarm and cyclic level together, cleared one at a time
		wr(`REG_CYC_SEL, 8'h0B);
		repeat (140) @(posedge clk_in);
		rchk(`REG_STATUS, 8'h0B);
		wr(`REG_CYC_SEL, 8'h00);
		wr(`REG_STATUS, 8'hFD);
		rchk(`REG_STATUS, 8'h09);
		chk_cond(irq_n === 1'b0, "alarm dropped with cyclic");
		wr(`REG_STATUS, 8'hFE);
		@(negedge clk_in);
		chk_cond(irq_n === 1'b1, "alarm not released");
		wr(`REG_CTRL, 8'h00);
		// Cyclic level mode holds until cleared
		wr(`REG_CYC_SEL, 8'h0B);
		until_lvl(0, 1'b0, 400, n);
		repeat (20) @(negedge clk_in);
		chk_cond(irq_n === 1'b0, "level request not held");
		rchk(`REG_STATUS, 8'h0A);
		wr(`REG_STATUS, 8'hFD);
		@(negedge clk_in);
		chk_cond(irq_n === 1'b1, "level request not cleared");
		wr(`REG_CYC_SEL, 8'h00);
		c0 = irq_falls;
		repeat (300) @(posedge clk_in);
		chk_cond(irq_falls == c0, "cyclic with zero selection");
		wr(`REG_CYC_SEL, 8'h07);
		repeat (100) @(posedge clk_in);
		chk_cond(irq_falls == c0, "cyclic with unused code");
		// Pulse mode periods for codes 1 to 5
		for (int c = 1; c <= 5; c++)
		begin
			wr(`REG_CYC_SEL, 8'(c));
			measure(0, per, wid);
			chk_cond(per == ticks[c] * TICK, "cyclic period");
			chk_cond(wid == TICK, "cyclic pulse width");
		end
		wr(`REG_CYC_SEL, 8'h01);
		// Timer period, restart in mid-period and during a pulse
		wr(`REG_TIMER_SEL, 8'h03);
		wr(`REG_CTRL, 8'h04);
		measure(1, per, wid);
		chk_cond(per == 32 * TICK && wid == TICK, "timer period");
		repeat (60) @(posedge clk_in);
		wr(`REG_CTRL, 8'h06);
		until_lvl(1, 1'b0, 400, n);
		chk_cond(n > 120 && n < 132, "restart did not clear count");
		wr(`REG_CTRL, 8'h06);
		@(negedge clk_in);
		chk_cond(tmr_n === 1'b1, "restart kept pulse");
		// Chip enable low halts the timer but not the cyclic interrupt
		@(posedge clk_in);
		ce <= 1'b0;
		repeat (6) @(posedge clk_in);
		c0 = tmr_falls;
		n = irq_falls;
		repeat (400) @(posedge clk_in);
		chk_cond(tmr_falls == c0, "timer ran with chip enable low");
		chk_cond(irq_falls > n + 40, "cyclic stopped with chip enable low");
		wr(`REG_CYC_SEL, 8'h09);
		repeat (12) @(posedge clk_in);
		rchk(`REG_STATUS, 8'h02);
		ce <= 1'b1;
		until_lvl(1, 1'b0, 300, n);
		chk_cond(n < 300, "timer did not resume");
		// Oscillator stop: flag set, gate cleared, pin stays off
		wr(`REG_CYC_SEL, 8'h00);
		osc_stop <= 1'b1;
		repeat (6) @(posedge clk_in);
		rchk(`REG_CTRL, 8'h00);
		rchk(`REG_STATUS, 8'h0C);
		c0 = tmr_falls;
		repeat (300) @(posedge clk_in);
		chk_cond(tmr_falls == c0, "timer pin after oscillator stop");
		conclude();
	end
endmodule : rtc_alarm_cyclic_timer_irq_bench
